/* src/bidir_shift_load_register.sv */
/*
 * Four-stage register that shifts right, shifts left or loads in
 * parallel, with an AHB-Lite register slave and cascade pins.
 * Assumes one clock, a synchronous active-high reset and neighbouring
 * sections that drive the cascade inputs from their own flip-flops.
 */
// The AHB-Lite interface to the registers and the register addresses were decided locally.
// Function
// - Multiplexer passes one of two 4-bit sources, one common select.
// - Enable is active low and common; outputs are active high.
// - With enable inactive all multiplexer outputs are low.
// - Select low routes the first source, select high the second.
// - Load control high shifts contents one stage right each rising edge.
// - Load control low captures all four parallel inputs each rising edge.
// - Each parallel input gets fresh data or its right neighbour's contents.
// - Stage n output feeds stage n-1 input, so bits move left.
// - End stages exchange shift bits with neighbouring sections for cascading.
`timescale 1ns/10ps
`include "shift_cfg.svh"

module bidir_shift_load_register (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic shift_right_in,
    input wire logic shift_left_in,
    output logic [`STAGES-1:0] stage_out
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ----------------------------------------
    // Cascade pin synchronisers
    // ----------------------------------------
    logic shr_s1_reg, shr_s2_reg, shl_s1_reg, shl_s2_reg;
    logic shr_s1_next, shr_s2_next, shl_s1_next, shl_s2_next;

    // Neighbours may run on another clock, so two flops before use
    always_comb begin
        shr_s1_next = shift_right_in;
        shr_s2_next = shr_s1_reg;
        shl_s1_next = shift_left_in;
        shl_s2_next = shl_s1_reg;
    end

    // Plain capture chain; no reset, the pins settle during reset anyway
    always_ff @(posedge clk_sys) begin
        shr_s1_reg <= shr_s1_next;
        shr_s2_reg <= shr_s2_next;
        shl_s1_reg <= shl_s1_next;
        shl_s2_reg <= shl_s2_next;
    end

    // ----------------------------------------
    // Bus slave and software registers
    // ----------------------------------------
    shift_pkg::ctrl_t ctrl_reg, ctrl_next;
    shift_pkg::nibble_t data_reg, data_next;
    shift_pkg::nibble_t stage_reg, stage_next;
    logic [`ADDR_W-1:0] waddr_reg, waddr_next;
    logic wpend_reg, wpend_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic [`STAGES-1:0] mux_out;
    logic take;

    // Address phase accepted only while the bus is ready
    assign take = hsel && hready && htrans[`HTRANS_ACTIVE_BIT];

    // Zero-wait slave: writes land in the data phase, reads sample at address phase
    always_comb begin
        ctrl_next = ctrl_reg;
        data_next = data_reg;
        wpend_next = take && hwrite;
        waddr_next = take ? haddr[`ADDR_W-1:0] : waddr_reg;
        hrdata_next = hrdata_reg;
        if (wpend_reg && hit(waddr_reg, `OFS_CTRL)) begin
            ctrl_next = shift_pkg::ctrl_t'(hwdata[`CTRL_W-1:0]);
        end
        if (wpend_reg && hit(waddr_reg, `OFS_DATA)) begin
            data_next = hwdata[`STAGES-1:0];
        end
        // A read in the data phase of a write still sees the older value
        if (take && !hwrite) begin
            hrdata_next = '0; // Unmapped reads return zero
            if (hit(haddr[`ADDR_W-1:0], `OFS_CTRL)) begin
                hrdata_next[`CTRL_W-1:0] = ctrl_reg;
            end else if (hit(haddr[`ADDR_W-1:0], `OFS_DATA)) begin
                hrdata_next[`STAGES-1:0] = data_reg;
            end else if (hit(haddr[`ADDR_W-1:0], `OFS_STAT)) begin
                hrdata_next[`STAGES-1:0] = stage_reg;
                hrdata_next[`STAT_MUX_LSB +: `STAGES] = mux_out;
            end
        end
    end

    // Bus registers; ready drops only while in reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= `CTRL_RST;
            data_reg <= `DATA_RST;
            wpend_reg <= 1'b0;
            waddr_reg <= '0;
            hrdata_reg <= '0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            data_reg <= data_next;
            wpend_reg <= wpend_next;
            waddr_reg <= waddr_next;
            hrdata_reg <= hrdata_next;
            hreadyout <= 1'b1; // Never stalls
            hresp <= 1'b0;     // Always OKAY
        end
    end

    // Read data straight from its flop
    assign hrdata = hrdata_reg;

    // ----------------------------------------
    // Parallel input multiplexer
    // ----------------------------------------
    shift_pkg::mux_src_t mux_src;

    // Source b is the stage to the right; stage 3 sees the next section
    assign mux_src.src_a = data_reg;
    assign mux_src.src_b = {shl_s2_reg, stage_reg[`STAGES-1:1]};

    // One select and one enable shared by all four bit slices
    quad_mux2 quad_mux2_i (
        .src(mux_src),
        .select(ctrl_reg.select),
        .mux_en_n(ctrl_reg.mux_en_n),
        .mux_out(mux_out)
    );

    // ----------------------------------------
    // Shift register stages
    // ----------------------------------------
    // Hold freezes the stages so software can step without racing the clock
    always_comb begin
        stage_next = stage_reg;
        if (!ctrl_reg.hold) begin
            if (ctrl_reg.parallel_load_n) begin
                stage_next = {stage_reg[`STAGES-2:0], shr_s2_reg};
            end else begin
                stage_next = mux_out;
            end
        end
    end

    // Stages clear on reset so software starts from a known word
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage_reg <= `STAGE_RST;
        end else begin
            stage_reg <= stage_next;
        end
    end

    assign stage_out = stage_reg; // End bits feed neighbour sections

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence seq_load;
        !ctrl_reg.hold && !ctrl_reg.parallel_load_n;
    endsequence

    sequence seq_left;
        seq_load ##0 (ctrl_reg.select && !ctrl_reg.mux_en_n);
    endsequence

    AST_MUX_SEL_A: assert property (
        !ctrl_reg.mux_en_n && !ctrl_reg.select |-> mux_out == data_reg)
        else $error("mux did not pass first source");
    AST_MUX_ACTIVE_HIGH: assert property (
        !ctrl_reg.mux_en_n && !ctrl_reg.select && data_reg[0] |-> mux_out[0])
        else $error("high input gave low output");
    AST_MUX_OFF: assert property (
        ctrl_reg.mux_en_n |-> mux_out == '0)
        else $error("disabled mux output not low");
    AST_SHIFT_RIGHT: assert property (
        !ctrl_reg.hold && ctrl_reg.parallel_load_n |=>
        stage_reg == {$past(stage_reg[`STAGES-2:0]), $past(shr_s2_reg)})
        else $error("right shift wrong");
    AST_LOAD: assert property (
        seq_load |=> stage_reg == $past(mux_out))
        else $error("parallel load wrong");
    AST_MUX_SEL_B: assert property (
        !ctrl_reg.mux_en_n && ctrl_reg.select |->
        mux_out == {shl_s2_reg, stage_reg[`STAGES-1:1]})
        else $error("mux did not pass neighbour source");
    AST_SHIFT_LEFT: assert property (
        seq_left |=> stage_reg == {$past(shl_s2_reg), $past(stage_reg[`STAGES-1:1])})
        else $error("left shift wrong");
    AST_CASCADE_IN: assert property (
        ##2 (shr_s2_reg == $past(shift_right_in, 2)) && (shl_s2_reg == $past(shift_left_in, 2)))
        else $error("cascade input not delayed two cycles");
    AST_HOLD: assert property (
        ctrl_reg.hold |=> $stable(stage_reg))
        else $error("stages moved while held");

endmodule : bidir_shift_load_register

/* src/shift_cfg.svh */
/*
 * Constants of the bidirectional shift and load register: bus offsets,
 * field widths and reset values.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef SHIFT_CFG_SVH
`define SHIFT_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_DATA 8'h04
`define OFS_STAT 8'h08
`define ADDR_W 8

// ----------------------------------------
// Field widths, bit positions and reset values
// ----------------------------------------
`define STAGES 4
`define CTRL_W 4
`define CTRL_RST 4'h9
`define DATA_RST 4'h0
`define STAGE_RST 4'h0
`define HTRANS_ACTIVE_BIT 1
`define STAT_MUX_LSB 4

`endif

/* src/shift_pkg.sv */
/*
 * Types shared by the shift register top and its input multiplexer.
 * Assumes shift_cfg.svh is on the include path.
 */
`include "shift_cfg.svh"

package shift_pkg;

    // Control word, bit 0 first from the bottom
    typedef struct packed {
        logic hold;
        logic mux_en_n;
        logic select;
        logic parallel_load_n;
    } ctrl_t;

    typedef logic [`STAGES-1:0] nibble_t;

    // Both multiplexer sources travel together
    typedef struct packed {
        nibble_t src_a;
        nibble_t src_b;
    } mux_src_t;

endpackage : shift_pkg

/* src/quad_mux2.sv */
/*
 * Quad two-input multiplexer with a common select and common active-low
 * enable; purely combinational.
 * Assumes the caller registers anything that must be glitch free.
 */
`timescale 1ns/10ps
`include "shift_cfg.svh"

module quad_mux2 (
    input wire shift_pkg::mux_src_t src,
    input wire logic select,
    input wire logic mux_en_n,
    output logic [`STAGES-1:0] mux_out
);

    // ----------------------------------------
    // One slice per bit position
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < `STAGES; i++) begin : g_bit
            // Disabled forces low; select low takes source a
            assign mux_out[i] = !mux_en_n && (select ? src.src_b[i] : src.src_a[i]);
        end
    endgenerate

endmodule : quad_mux2

/* tb/nbr_section.sv */
/*
 * Neighbouring register sections at both cascade ends, reduced to
 * their end-stage flops.
 * Assumes the bench seeds the generator once and holds rst at start.
 */
`timescale 1ns/10ps

module nbr_section (
    input wire logic clk_sys,
    input wire logic rst,
    output logic right_bit,
    output logic left_bit
);
    // End-stage flops; a fresh bit each edge so a stale sync shows up
    always_ff @(posedge clk_sys) begin
        right_bit <= rst ? 1'b0 : 1'($urandom);
        left_bit <= rst ? 1'b0 : 1'($urandom);
    end
endmodule : nbr_section

/* tb/bidir_shift_load_register_tb.sv */
/*
 * Self-checking bench: AHB-Lite master, reference model, mode sweep.
 * Assumes zero-wait slave and two-flop sync on both cascade pins.
 */
`timescale 1ns/10ps

module bidir_shift_load_register_tb;
    logic clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp, sri, sli, wp, lm, m_rdy;
    logic [31:0] haddr, hwdata, hrdata, m_rd, rd;
    logic [1:0] htrans, sr, sl;
    logic [3:0] stage_out, m_stage, m_ctrl, m_data;
    logic [7:0] wa;
    int n_errors, checks_done;
    assign hready = hreadyout;

    bidir_shift_load_register bidir_shift_load_register_i (.clk_sys(clk_sys), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .shift_right_in(sri), .shift_left_in(sli), .stage_out(stage_out));
    nbr_section nbr_section_i (.clk_sys(clk_sys), .rst(rst), .right_bit(sri), .left_bit(sli));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Reference model
    // ----------------------------------------
    function automatic logic [3:0] mux_m();
        return m_ctrl[2] ? 4'h0 : (m_ctrl[1] ? {sl[1], m_stage[3:1]} : m_data);
    endfunction : mux_m

    // Blocking updates at the edge see pre-edge inputs, as the flops do
    always @(posedge clk_sys) begin
        if (rst) begin
            m_stage = 4'h0;
            m_ctrl = 4'h9;
            m_data = 4'h0;
            sr = 2'h0;
            sl = 2'h0;
            wp = 1'b0;
            m_rdy = 1'b0;
        end else begin
            if (hsel && hready && htrans[1] && !hwrite) begin
                m_rd = (haddr[7:0] == 8'h00) ? {28'h0, m_ctrl} : (haddr[7:0] == 8'h04) ?
                    {28'h0, m_data} : (haddr[7:0] == 8'h08) ? {24'h0, mux_m(), m_stage} : 32'h0;
            end
            lm = m_ctrl[0];
            if (!m_ctrl[3]) m_stage = m_ctrl[0] ? {m_stage[2:0], sr[1]} : mux_m();
            if (wp && wa == 8'h00) m_ctrl = hwdata[3:0];
            if (wp && wa == 8'h04) m_data = hwdata[3:0];
            wp = hsel && hready && htrans[1] && hwrite;
            wa = haddr[7:0];
            sr = {sr[0], sri};
            sl = {sl[0], sli};
            m_rdy = 1'b1;
        end
    end

    // Outputs compared mid-cycle, once the edge has settled
    always @(negedge clk_sys) begin
        if (!rst && lm === 1'b1) check(32'(stage_out), 32'(m_stage));
        else if (!rst) check(32'(stage_out), 32'(m_stage));
        check(32'(hreadyout), 32'(m_rdy));
        check(32'(hresp), 32'h0);
    end

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // No pipelining: each transfer completes before the next starts
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic rd_chk(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
        check(rd, m_rd);
        check(32'(hresp), 32'h0);
    endtask : rd_chk

    task automatic conclude();
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        rst = 1'b1;
        n_errors = 0;
        checks_done = 0;
        void'($urandom(49));
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd_chk(8'h00);
        rd_chk(8'h04);
        // Every mode, run for 2..6 edges, then frozen and read back
        for (int i = 0; i < 48; i++) begin
            xfer(1'b1, 8'h04, $urandom);
            xfer(1'b1, 8'h08, $urandom);
            xfer(1'b1, 8'h00, 32'(i % 8));
            repeat (i % 5) @(posedge clk_sys);
            xfer(1'b1, 8'h00, 32'(8 + i % 8));
            rd_chk(8'h08);
            rd_chk(8'h00);
            rd_chk(8'h0c);
        end
        // Reset on the first right-shift edge: stages and control return to rest values
        xfer(1'b1, 8'h00, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd_chk(8'h00);
        rd_chk(8'h08);
        conclude();
    end

    // Sweep needs about 800 cycles; generous margin
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        conclude();
    end
endmodule : bidir_shift_load_register_tb
